/* File: core/dup_filter_pkg.sv */
// Shared types, register map and constants of the duplicate code filter
package dup_filter_pkg;
  localparam int CODE_BITS = 64;
  localparam int LEN_W     = 7;
  localparam int POS_W     = 16;
  localparam int AGE_W     = 16;
  localparam int ADDR_W    = 8;

  typedef struct packed {
    logic [CODE_BITS-1:0] content;
    logic [LEN_W-1:0]     len;
    logic [POS_W-1:0]     x;
    logic [POS_W-1:0]     y;
    logic [POS_W-1:0]     z;
  } code_t;

  typedef struct packed {
    logic  no_read;
    code_t code;
  } msg_t;

  typedef enum logic [1:0] {crit_none, crit_timeout, crit_steps, crit_txline} crit_t;

  localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] REG_TIMEOUT  = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STEPS    = 8'h08;
  localparam logic [ADDR_W-1:0] REG_TXLINE   = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h10;
  localparam logic [ADDR_W-1:0] REG_ACCEPTED = 8'h14;
  localparam logic [ADDR_W-1:0] REG_DROPPED  = 8'h18;

  localparam int CTRL_CONT_BIT  = 0;
  localparam int CTRL_CRIT_LSB  = 1;
  localparam int CTRL_DEPTH_LSB = 8;
  localparam int STAT_FULL_BIT  = 8;

  localparam logic [6:0]       DEPTH_RESET   = 7'h00;
  localparam logic [AGE_W-1:0] TIMEOUT_MIN   = 16'h0028;
  localparam logic [AGE_W-1:0] TIMEOUT_MAX   = 16'h3a98;
  localparam logic [AGE_W-1:0] STEPS_MIN     = 16'h0001;
  localparam logic [AGE_W-1:0] STEPS_MAX     = 16'h3a98;
  localparam logic [AGE_W-1:0] TXLINE_RESET  = 16'h0064;

  localparam int CLOCK_HZ      = 250_000_000;
  localparam int TICK_TIME_MS  = 1;
  localparam int MS_CYCLES_DEF = CLOCK_HZ / 1000 * TICK_TIME_MS;
endpackage

/* File: core/duplicate_code_filter_list.sv */
// Duplicate-read filter list between the code decoder and the message transmitter
//
// Functional notes
// (RQ1) Continuous mode keeps the reading phase active all the time.
// (RQ2) Continuous mode sends nothing on a failed read; good reads go out normally.
// (RQ3) Flush criterion selects none, timeout, encoder steps or transmit-line distance.
// (RQ4) Two codes match only when content and length are both equal.
// (RQ5) Criterion none: entries leave only by overflow on a new accepted code.
// (RQ6) Timeout criterion: each entry has a millisecond timer, removed on expiry.
// (RQ7) Step criterion: entry removed once its encoder step count exceeds the threshold.
// (RQ8) Transmit-line criterion: entry removed once its travelled millimetres exceed the distance.
// (RQ9) Transmit-line mode ignores the depth setting and uses the whole internal list.
// (RQ10) Transmit-line mode: duplicate dropped, stored x, y, z become the mean.
// (RQ11) List depth is configurable from 0 to 127.
// (RQ12) A new code matching any held entry is dropped.
// (RQ13) A new unmatched code is accepted and inserted at the head, others shift.
// (RQ14) Inserting into a full list evicts the oldest entry.
// (RQ15) Depth zero disables filtering; every code passes.
// (RQ16) Timeout and step ageing act alongside overflow; first condition wins.
// (RQ17) Timeout limit is configurable from 40 to 15000 ms.
// (RQ18) Encoder step threshold is configurable from 1 to 15000 steps.
// (RQ19) Entry counters start at insertion; aged removal keeps the order of others.
`timescale 1ns/1ps
module duplicate_code_filter_list #(
  parameter int MAX_DEPTH = 127,
  parameter int MS_CYCLES = dup_filter_pkg::MS_CYCLES_DEF,
  parameter int OUT_DEPTH = 8
) (
  input  wire logic                               clock,
  input  wire logic                               rst,
  input  wire logic [dup_filter_pkg::ADDR_W-1:0]  address,
  input  wire logic                               read,
  input  wire logic                               write,
  input  wire logic [31:0]                        writedata,
  output logic      [31:0]                        readdata,
  output logic                                    waitrequest,
  input  wire logic                               phase_trigger,
  output logic                                    reading_active,
  input  wire logic                               dec_valid,
  output logic                                    dec_ready,
  input  wire logic                               dec_fail,
  input  wire dup_filter_pkg::code_t              dec_code,
  input  wire logic                               enc_step,
  input  wire logic                               mm_tick,
  output logic                                    tx_valid,
  input  wire logic                               tx_ready,
  output dup_filter_pkg::msg_t                    tx_msg
);
  localparam int AW = dup_filter_pkg::AGE_W;
  localparam int MW = $bits(dup_filter_pkg::msg_t);

  if (MAX_DEPTH < 1 || MAX_DEPTH > 127 || MS_CYCLES < 1) begin : g_bad
    $error("duplicate_code_filter_list: MAX_DEPTH must be 1..127, MS_CYCLES >= 1");
  end

  // Configuration and status
  logic                  cont_mode;
  dup_filter_pkg::crit_t crit;
  logic [6:0]            depth_cfg;
  logic [AW-1:0]         timeout_ms;
  logic [AW-1:0]         step_limit;
  logic [AW-1:0]         txline_mm;
  logic [31:0]           accept_cnt;
  logic [31:0]           drop_cnt;
  logic                  ack;

  // List storage
  dup_filter_pkg::code_t ent [MAX_DEPTH];
  logic [AW-1:0]         age [MAX_DEPTH];
  logic [MAX_DEPTH-1:0]  valid;
  logic [MAX_DEPTH-1:0]  slot_on;
  logic [MAX_DEPTH-1:0]  hit;
  logic [MAX_DEPTH-1:0]  expire;
  logic [MAX_DEPTH:0]    hole_below;
  logic [6:0]            eff_depth;
  logic                  filter_on;
  logic                  any_hit;
  logic                  take;
  logic                  is_dup;
  logic                  insert;
  logic                  push;
  logic                  fifo_ready;
  logic                  age_tick;
  logic                  ms_tick;
  logic [31:0]           ms_cnt;
  dup_filter_pkg::msg_t  next_msg;
  logic [MW-1:0]         fifo_out;

  function automatic logic codes_match(input dup_filter_pkg::code_t a,
                                       input dup_filter_pkg::code_t b);
    return (a.content == b.content) && (a.len == b.len);
  endfunction

  function automatic logic [dup_filter_pkg::POS_W-1:0] mean_pos(
      input logic [dup_filter_pkg::POS_W-1:0] a,
      input logic [dup_filter_pkg::POS_W-1:0] b);
    logic [dup_filter_pkg::POS_W:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    return sum[dup_filter_pkg::POS_W:1];
  endfunction

  function automatic logic [AW-1:0] clamp(input logic [31:0] v,
                                          input logic [AW-1:0] lo,
                                          input logic [AW-1:0] hi);
    if (v < {16'h0000, lo}) begin
      return lo;
    end else if (v > {16'h0000, hi}) begin
      return hi;
    end
    return v[AW-1:0];
  endfunction

  function automatic logic [7:0] count_ones(input logic [MAX_DEPTH-1:0] v);
    logic [7:0] n;
    n = 8'h00;
    for (int k = 0; k < MAX_DEPTH; k++) begin
      n = n + {7'h00, v[k]};
    end
    return n;
  endfunction

  // (RQ1) Reading phase held
  assign reading_active = cont_mode || phase_trigger;

  // (RQ9) Depth from list size
  assign eff_depth = (crit == dup_filter_pkg::crit_txline) ? 7'(MAX_DEPTH) :
                     (depth_cfg > 7'(MAX_DEPTH)) ? 7'(MAX_DEPTH) : depth_cfg;
  // (RQ15) Zero depth bypass
  assign filter_on = (eff_depth != 7'h00);
  assign any_hit   = |hit;

  assign dec_ready = fifo_ready;
  assign take      = dec_valid && dec_ready;
  // (RQ12) Drop matched code
  assign is_dup    = take && !dec_fail && filter_on && any_hit;
  // (RQ13) Accept unmatched code
  assign insert    = take && !dec_fail && filter_on && !any_hit;
  // (RQ2) Silent failed read
  assign push      = take && !is_dup && !(dec_fail && cont_mode);

  always_comb begin
    next_msg.no_read = dec_fail;
    next_msg.code    = dec_fail ? '0 : dec_code;
  end

  // (RQ3) Ageing source select
  always_comb begin
    case (crit)
      dup_filter_pkg::crit_timeout: age_tick = ms_tick;
      dup_filter_pkg::crit_steps:   age_tick = enc_step;
      dup_filter_pkg::crit_txline:  age_tick = mm_tick;
      default:                      age_tick = 1'b0;
    endcase
  end

  assign ms_tick = (ms_cnt == 32'(MS_CYCLES - 1));

  // (RQ6) Millisecond time base
  always_ff @(posedge clock) begin
    if (rst || ms_tick) begin
      ms_cnt <= 32'h0000_0000;
    end else begin
      ms_cnt <= ms_cnt + 32'h0000_0001;
    end
  end

  assign hole_below[0] = 1'b0;

  for (genvar i = 0; i < MAX_DEPTH; i++) begin : g_ent
    logic shift;

    assign slot_on[i]      = (7'(i) < eff_depth);
    assign hole_below[i+1] = hole_below[i] || !valid[i];
    // (RQ4) Content and length compare
    assign hit[i]          = valid[i] && slot_on[i] && codes_match(ent[i], dec_code);
    // (RQ14) Shift past full slots
    assign shift           = insert && (i != 0) && !hole_below[i];

    always_comb begin
      case (crit)
        // (RQ6) Timer expiry
        dup_filter_pkg::crit_timeout: expire[i] = (age[i] >= timeout_ms);
        // (RQ7) Step limit exceeded
        dup_filter_pkg::crit_steps:   expire[i] = (age[i] > step_limit);
        // (RQ8) Distance exceeded
        dup_filter_pkg::crit_txline:  expire[i] = (age[i] > txline_mm);
        // (RQ5) Overflow only
        default:                      expire[i] = 1'b0;
      endcase
    end

    // (RQ16) First removal wins
    always_ff @(posedge clock) begin
      if (rst || !slot_on[i]) begin
        valid[i] <= 1'b0;
      end else if (insert && i == 0) begin
        valid[i] <= 1'b1;
      end else if (shift) begin
        valid[i] <= valid[(i == 0) ? 0 : i-1];
      end else if (expire[i]) begin
        // (RQ19) Holes keep order
        valid[i] <= 1'b0;
      end
    end

    // (RQ19) Counter starts at insert
    always_ff @(posedge clock) begin
      if (rst) begin
        age[i] <= '0;
      end else if (insert && i == 0) begin
        age[i] <= '0;
      end else if (shift) begin
        age[i] <= age[(i == 0) ? 0 : i-1];
      end else if (valid[i] && age_tick && age[i] != '1) begin
        age[i] <= age[i] + 1'b1;
      end
    end

    always_ff @(posedge clock) begin
      if (insert && i == 0) begin
        ent[i] <= dec_code;
      end else if (shift) begin
        ent[i] <= ent[(i == 0) ? 0 : i-1];
      end else if (is_dup && hit[i] && crit == dup_filter_pkg::crit_txline) begin
        // (RQ10) Average coordinates
        ent[i].x <= mean_pos(ent[i].x, dec_code.x);
        ent[i].y <= mean_pos(ent[i].y, dec_code.y);
        ent[i].z <= mean_pos(ent[i].z, dec_code.z);
      end
    end
  end

  msg_fifo #(
    .WIDTH (MW),
    .DEPTH (OUT_DEPTH)
  ) u_out_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (next_msg),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (fifo_out)
  );

  assign tx_msg = dup_filter_pkg::msg_t'(fifo_out);

  always_ff @(posedge clock) begin
    if (rst) begin
      accept_cnt <= 32'h0000_0000;
      drop_cnt   <= 32'h0000_0000;
    end else begin
      if (push && !dec_fail) begin
        accept_cnt <= accept_cnt + 32'h0000_0001;
      end
      if (is_dup) begin
        drop_cnt <= drop_cnt + 32'h0000_0001;
      end
    end
  end

  // Avalon-MM slave: every access answers after one wait cycle
  assign waitrequest = (read || write) && !ack;

  always_ff @(posedge clock) begin
    if (rst) begin
      ack <= 1'b0;
    end else begin
      ack <= (read || write) && !ack;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cont_mode  <= 1'b0;
      crit       <= dup_filter_pkg::crit_none;
      depth_cfg  <= dup_filter_pkg::DEPTH_RESET;
      timeout_ms <= dup_filter_pkg::TIMEOUT_MIN;
      step_limit <= dup_filter_pkg::STEPS_MIN;
      txline_mm  <= dup_filter_pkg::TXLINE_RESET;
    end else if (write && ack) begin
      case (address)
        dup_filter_pkg::REG_CTRL: begin
          cont_mode <= writedata[dup_filter_pkg::CTRL_CONT_BIT];
          crit      <= dup_filter_pkg::crit_t'(writedata[dup_filter_pkg::CTRL_CRIT_LSB +: 2]);
          // (RQ11) Depth 0 to 127
          depth_cfg <= writedata[dup_filter_pkg::CTRL_DEPTH_LSB +: 7];
        end
        // (RQ17) Timeout range
        dup_filter_pkg::REG_TIMEOUT: timeout_ms <= clamp(writedata,
            dup_filter_pkg::TIMEOUT_MIN, dup_filter_pkg::TIMEOUT_MAX);
        // (RQ18) Step range
        dup_filter_pkg::REG_STEPS:   step_limit <= clamp(writedata,
            dup_filter_pkg::STEPS_MIN, dup_filter_pkg::STEPS_MAX);
        dup_filter_pkg::REG_TXLINE:  txline_mm <= writedata[AW-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (read && !ack) begin
      case (address)
        dup_filter_pkg::REG_CTRL:     readdata <= {17'h0_0000, depth_cfg, 5'h00,
                                                   crit, cont_mode};
        dup_filter_pkg::REG_TIMEOUT:  readdata <= {16'h0000, timeout_ms};
        dup_filter_pkg::REG_STEPS:    readdata <= {16'h0000, step_limit};
        dup_filter_pkg::REG_TXLINE:   readdata <= {16'h0000, txline_mm};
        dup_filter_pkg::REG_STATUS:   readdata <= {23'h00_0000,
                                                   filter_on && !hole_below[eff_depth],
                                                   count_ones(valid & slot_on)};
        dup_filter_pkg::REG_ACCEPTED: readdata <= accept_cnt;
        dup_filter_pkg::REG_DROPPED:  readdata <= drop_cnt;
        default:                      readdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

/* File: core/msg_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module msg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || WIDTH < 1) begin : g_bad
    $error("msg_fifo needs DEPTH >= 2 and WIDTH >= 1");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count < (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

/* File: testbench/dup_filter_chk.sv */
// Assertions on the ports of the duplicate code filter list
`timescale 1ns/1ps
module dup_filter_chk (
  input wire logic                              clock,
  input wire logic                              rst,
  input wire logic [dup_filter_pkg::ADDR_W-1:0] address,
  input wire logic                              read,
  input wire logic                              write,
  input wire logic [31:0]                       writedata,
  input wire logic [31:0]                       readdata,
  input wire logic                              waitrequest,
  input wire logic                              phase_trigger,
  input wire logic                              reading_active,
  input wire logic                              dec_valid,
  input wire logic                              dec_ready,
  input wire logic                              dec_fail,
  input wire dup_filter_pkg::code_t             dec_code,
  input wire logic                              enc_step,
  input wire logic                              mm_tick,
  input wire logic                              tx_valid,
  input wire logic                              tx_ready,
  input wire dup_filter_pkg::msg_t              tx_msg
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [31:0] ctrl;
  logic        take;
  assign take = dec_valid && dec_ready;
  // Shadow of the control word
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl <= 32'h0000_0000;
    end else if (write && !waitrequest && address == dup_filter_pkg::REG_CTRL) begin
      ctrl <= writedata;
    end
  end
  AST_ONE_WAIT: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("access waited more than one cycle");
  AST_IDLE: assert property (!(read || write) |-> !waitrequest)
    else $error("waitrequest without access");
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_msg))
    else $error("output message changed while stalled");
  AST_CONT_ACTIVE: assert property (ctrl[0] |-> reading_active)
    else $error("reading phase inactive in continuous mode");
  AST_TRIG: assert property (!ctrl[0] |-> reading_active == phase_trigger)
    else $error("reading phase does not follow trigger");
  AST_CONT_FAIL: assert property (ctrl[0] && take && dec_fail && !tx_valid |=> !tx_valid)
    else $error("failed read sent in continuous mode");
  AST_FAIL_MSG: assert property (!ctrl[0] && take && dec_fail && !tx_valid
    |=> tx_valid && tx_msg.no_read) else $error("failed read not reported");
  AST_PASS: assert property (ctrl[14:8] == 7'h00 && ctrl[2:1] != 2'h3 && take && !dec_fail
    && !tx_valid |=> tx_valid && tx_msg.code == $past(dec_code))
    else $error("code not passed through");
  AST_TIMEOUT_RANGE: assert property (read && !waitrequest && address == dup_filter_pkg::REG_TIMEOUT
    |-> readdata inside {[dup_filter_pkg::TIMEOUT_MIN:dup_filter_pkg::TIMEOUT_MAX]})
    else $error("timeout limit out of range");
  AST_STEPS_RANGE: assert property (read && !waitrequest && address == dup_filter_pkg::REG_STEPS
    |-> readdata inside {[dup_filter_pkg::STEPS_MIN:dup_filter_pkg::STEPS_MAX]})
    else $error("step limit out of range");
endmodule
bind duplicate_code_filter_list dup_filter_chk dup_filter_chk_i (.clock(clock), .rst(rst),
  .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .phase_trigger(phase_trigger), .reading_active(reading_active),
  .dec_valid(dec_valid), .dec_ready(dec_ready), .dec_fail(dec_fail), .dec_code(dec_code),
  .enc_step(enc_step), .mm_tick(mm_tick), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_msg(tx_msg));

/* File: testbench/duplicate_code_filter_list_tb_top.sv */
// Self-checking bench of the duplicate code filter list
`timescale 1ns/1ps
module duplicate_code_filter_list_tb_top;
  logic                  clock = 1'b0;
  logic                  rst = 1'b1;
  logic [7:0]            address = 8'h00;
  logic                  read = 1'b0;
  logic                  write = 1'b0;
  logic [31:0]           writedata = 32'h0000_0000;
  logic [31:0]           readdata;
  logic                  waitrequest;
  logic                  phase_trigger = 1'b1;
  logic                  reading_active;
  logic                  dec_valid = 1'b0;
  logic                  dec_ready;
  logic                  dec_fail = 1'b0;
  dup_filter_pkg::code_t dec_code = '0;
  logic                  enc_step = 1'b0;
  logic                  mm_tick = 1'b0;
  logic                  tx_valid;
  logic                  tx_ready;
  dup_filter_pkg::msg_t  tx_msg;
  logic                  stall = 1'b0;
  logic [47:0]           pos = 48'h0000_0000_0000;
  int                    n_mismatch = 0;
  int                    checks = 0;

  always #2 clock = ~clock;

  duplicate_code_filter_list #(.MS_CYCLES(4)) duplicate_code_filter_list_i (.clock(clock),
    .rst(rst), .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .phase_trigger(phase_trigger),
    .reading_active(reading_active), .dec_valid(dec_valid), .dec_ready(dec_ready),
    .dec_fail(dec_fail), .dec_code(dec_code), .enc_step(enc_step), .mm_tick(mm_tick),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_msg(tx_msg));
  tx_sink tx_sink_i (.clock(clock), .stall(stall), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_msg(tx_msg));

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do begin @(posedge clock); end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic cfg(input logic [31:0] c);
    logic [31:0] q;
    bus(1'b1, dup_filter_pkg::REG_CTRL, 32'h0000_0000, q);
    bus(1'b1, dup_filter_pkg::REG_CTRL, c, q);
  endtask

  task automatic send(input logic [63:0] c, input logic [6:0] l, input logic f);
    dec_valid <= 1'b1;
    dec_fail <= f;
    dec_code <= {c, l, pos};
    do begin @(posedge clock); end while (dec_ready !== 1'b1);
    dec_valid <= 1'b0;
    dec_code <= ~{c, l, 48'h0000_0000_0000};
    @(posedge clock);
  endtask

  task automatic expect_out(input int n, input logic [63:0] c, input logic nr);
    repeat (12) @(posedge clock);
    chk(tx_sink_i.got.size(), n);
    if (n > 0 && tx_sink_i.got.size() > 0) begin
      chk(tx_sink_i.got[0].code.content, c);
      chk(tx_sink_i.got[0].no_read, nr);
    end
    tx_sink_i.got.delete();
  endtask

  task automatic pulse(input int n, input logic mm);
    repeat (n) begin
      if (mm) mm_tick <= 1'b1; else enc_step <= 1'b1;
      @(posedge clock);
      mm_tick <= 1'b0;
      enc_step <= 1'b0;
      @(posedge clock);
    end
  endtask

  task automatic t_regs();
    logic [31:0] q;
    bus(1'b0, dup_filter_pkg::REG_CTRL, 32'h0000_0000, q); chk(q, 32'h0000_0000);
    bus(1'b0, dup_filter_pkg::REG_TIMEOUT, 32'h0000_0000, q); chk(q, 32'h0000_0028);
    bus(1'b0, dup_filter_pkg::REG_TXLINE, 32'h0000_0000, q); chk(q, 32'h0000_0064);
    bus(1'b1, dup_filter_pkg::REG_TIMEOUT, 32'h0000_4e20, q);
    bus(1'b0, dup_filter_pkg::REG_TIMEOUT, 32'h0000_0000, q); chk(q, 32'h0000_3a98);
    bus(1'b1, dup_filter_pkg::REG_STEPS, 32'h0000_0000, q);
    bus(1'b0, dup_filter_pkg::REG_STEPS, 32'h0000_0000, q); chk(q, 32'h0000_0001);
    bus(1'b1, 8'h40, 32'hffff_ffff, q);
    bus(1'b0, 8'h40, 32'h0000_0000, q); chk(q, 32'h0000_0000);
  endtask

  task automatic t_fail();
    cfg(32'h0000_0000);
    phase_trigger <= 1'b0;
    @(posedge clock);
    chk(reading_active, 1'b0);
    send(64'h0000_0000_0000_000a, 7'h05, 1'b0); expect_out(1, 64'h0000_0000_0000_000a, 1'b0);
    send(64'h0000_0000_0000_000a, 7'h05, 1'b0); expect_out(1, 64'h0000_0000_0000_000a, 1'b0);
    send(64'h0000_0000_0000_000a, 7'h05, 1'b1); expect_out(1, 64'h0000_0000_0000_0000, 1'b1);
    cfg(32'h0000_0001);
    chk(reading_active, 1'b1);
    send(64'h0000_0000_0000_000a, 7'h05, 1'b1); expect_out(0, 64'h0000_0000_0000_0000, 1'b0);
    send(64'h0000_0000_0000_000c, 7'h05, 1'b0); expect_out(1, 64'h0000_0000_0000_000c, 1'b0);
  endtask

  task automatic t_table();
    logic [7:0] seq[9] = '{8'h0a, 8'h0b, 8'h0b, 8'h0c, 8'h0d, 8'h0a, 8'h0a, 8'h0a, 8'h0a};
    logic [6:0] len[9] = '{7'h05, 7'h05, 7'h05, 7'h05, 7'h05, 7'h05, 7'h05, 7'h06, 7'h05};
    int acc[9] = '{1, 1, 0, 1, 1, 1, 0, 1, 0};
    logic [31:0] q;
    cfg(32'h0000_0300);
    foreach (seq[i]) begin
      send({56'h0000_0000_0000_00, seq[i]}, len[i], 1'b0);
      expect_out(acc[i], {56'h0000_0000_0000_00, seq[i]}, 1'b0);
    end
    bus(1'b0, dup_filter_pkg::REG_STATUS, 32'h0000_0000, q); chk(q, 32'h0000_0103);
    bus(1'b0, dup_filter_pkg::REG_DROPPED, 32'h0000_0000, q); chk(q, 32'h0000_0003);
  endtask

  task automatic t_age(input logic [31:0] c, input logic [7:0] a, input logic mm);
    logic [31:0] q;
    logic [47:0] p;
    bus(1'b1, a, 32'h0000_0002, q);
    cfg(c);
    send(64'h0000_0000_0000_00a1, 7'h05, 1'b0); expect_out(1, 64'h0000_0000_0000_00a1, 1'b0);
    pulse(2, mm);
    pos = 48'h0004_0008_000c;
    send(64'h0000_0000_0000_00a1, 7'h05, 1'b0); expect_out(0, 64'h0000_0000_0000_0000, 1'b0);
    pos = 48'h0000_0000_0000;
    p = {duplicate_code_filter_list_i.ent[0].x, duplicate_code_filter_list_i.ent[0].y,
         duplicate_code_filter_list_i.ent[0].z};
    // Averaging only in transmit-line mode
    chk(p, mm ? 48'h0002_0004_0006 : 48'h0000_0000_0000);
    pulse(1, mm);
    send(64'h0000_0000_0000_00a1, 7'h05, 1'b0); expect_out(1, 64'h0000_0000_0000_00a1, 1'b0);
  endtask

  task automatic t_time();
    logic [63:0] a = 64'h0000_0000_0000_0001;
    logic [31:0] q;
    bus(1'b1, dup_filter_pkg::REG_TIMEOUT, 32'h0000_0028, q);
    cfg(32'h0000_0302);
    send(a, 7'h05, 1'b0); expect_out(1, a, 1'b0);
    repeat (80) @(posedge clock);
    send(a, 7'h05, 1'b0); expect_out(0, a, 1'b0);
    repeat (200) @(posedge clock);
    send(a, 7'h05, 1'b0); expect_out(1, a, 1'b0);
    cfg(32'h0000_0102);
    send(a, 7'h05, 1'b0); expect_out(1, a, 1'b0);
    send(~a, 7'h05, 1'b0); expect_out(1, ~a, 1'b0);
    send(a, 7'h05, 1'b0); expect_out(1, a, 1'b0);
  endtask

  task automatic t_fifo();
    stall <= 1'b1;
    cfg(32'h0000_0000);
    for (int i = 0; i < 8; i++) send({56'h0000_0000_0000_00, 8'(i)}, 7'h05, 1'b0);
    @(negedge clock);
    chk(dec_ready, 1'b0);
    stall <= 1'b0;
    expect_out(8, 64'h0000_0000_0000_0000, 1'b0);
  endtask

  task automatic wrap_up();
    if (n_mismatch == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_regs();
    t_fail();
    t_table();
    t_time();
    t_age(32'h0000_0304, dup_filter_pkg::REG_STEPS, 1'b0);
    t_age(32'h0000_0006, dup_filter_pkg::REG_TXLINE, 1'b1);
    t_fifo();
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    wrap_up();
  end
endmodule

/* File: testbench/tx_sink.sv */
// Transmitter model that takes messages and can stall
`timescale 1ns/1ps
module tx_sink (
  input  wire logic                 clock,
  input  wire logic                 stall,
  input  wire logic                 tx_valid,
  output logic                      tx_ready,
  input  wire dup_filter_pkg::msg_t tx_msg
);
  dup_filter_pkg::msg_t got[$];
  assign tx_ready = !stall;
  always @(posedge clock) begin
    if (tx_valid && tx_ready) begin
      got.push_back(tx_msg);
    end
  end
endmodule
